// ### hw/regbank_defs.svh
`ifndef REGBANK_DEFS_SVH
`define REGBANK_DEFS_SVH

// register indices on the serial host port
`define ADDR_PIN_READBACK   7'h35
`define ADDR_CONV_CONTROL   7'h36

// control register field positions
`define CTRL_AUTO_BIT       13
`define CTRL_TRIG_BIT       12
`define CTRL_LOAD_BIT       11
`define CTRL_RATE_HI        9
`define CTRL_RATE_LO        8

// reset and writable-bit masks of the control register
`define CTRL_RESET          16'h2000
`define CTRL_WMASK          16'h3B00

// pin readback pin count and rate encoding
`define PIN_COUNT           12
`define RATE_500K           2'h0

// serial frame: 8 command bits then 16 data bits
`define CMD_LAST            5'h07
`define DATA_LAST           5'h0F

`endif

// ### hw/regbank_pkg.sv
package regbank_pkg;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_CMD  = 3'b010,
    PH_DATA = 3'b100
  } phase_t;

  typedef struct packed {
    logic [14:0] s1;
    logic [14:0] s2;
  } sync_state_t;

  typedef struct packed {
    phase_t      phase;
    logic        sclk_q;
    logic [4:0]  bit_cnt;
    logic        rw;
    logic [15:0] shin;
    logic [15:0] shout;
    logic        sdo;
    logic        sdo_oe;
    logic [15:0] ctrl;
    logic        trig_pulse;
    logic        load_pulse;
    logic [3:0]  dac_pending;
    logic [3:0]  dac_update;
    logic [11:0] pin_drv;
    logic [11:0] pin_oe;
  } main_state_t;

endpackage : regbank_pkg

// ### hw/pin_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for the serial port pins and the twelve gpio pins
module pin_sync2 (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [14:0] async_i,
  output var  logic [14:0] sync_o
);

  regbank_pkg::sync_state_t st_reg;
  regbank_pkg::sync_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // chip select idles high; resetting it low only costs a two-cycle false frame start
  assign sync_o = st_reg.s2;

endmodule : pin_sync2

`default_nettype wire

// ### hw/gpio_conv_regbank.sv
// What this block does
// (RULE1) output pins read back the value held in their output-drive bit
// (RULE2) readback bits 15:12 always read zero
// (RULE3) control bit 13 picks automatic (1) or direct (0) conversion, resets to one
// (RULE4) writing one to bit 12 starts a conversion; the bit then clears itself
// (RULE5) writing one to bit 11 loads every sync-selected analog output channel
// (RULE6) that load updates only channels written since their own last update
// (RULE7) bits 9:8 pick the conversion rate; 00 (reset) is 500 kSPS
// (RULE8) control register resets to 0x2000
// (RULE9) direction bit zero leaves the pin undriven, one drives it
// (RULE10) input pins read back their synchronised pin level
// (RULE11) load bit is a single pulse and reads zero once applied
`timescale 1ns/1ps
`include "regbank_defs.svh"
`default_nettype none

module gpio_conv_regbank (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        spi_csn_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_sdi_i,
  output var  logic        spi_sdo_o,
  output var  logic        spi_sdo_oe_o,
  input  wire logic [11:0] gpio_dir_i,
  input  wire logic [11:0] gpio_out_i,
  input  wire logic [11:0] gpio_pin_i,
  output var  logic [11:0] gpio_pin_o,
  output var  logic [11:0] gpio_pin_oe_o,
  input  wire logic [3:0]  dac_sync_i,
  input  wire logic [3:0]  dac_data_wr_i,
  output var  logic [3:0]  dac_update_o,
  output var  logic        dac_load_o,
  output var  logic        conv_trigger_o,
  output var  logic        conv_auto_o,
  output var  logic [1:0]  conv_rate_o
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [14:0] sync_w;
  logic        csn_s;
  logic        sclk_s;
  logic        sdi_s;
  logic [11:0] pin_s;

  // all pin groups share one synchroniser so they keep the same lag
  pin_sync2 u_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .async_i  ({spi_csn_i, spi_sclk_i, spi_sdi_i, gpio_pin_i}),
    .sync_o   (sync_w)
  );

  assign csn_s  = sync_w[14];
  assign sclk_s = sync_w[13];
  assign sdi_s  = sync_w[12];
  assign pin_s  = sync_w[11:0];

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // readback is a snapshot taken when the index arrives; a pin that moves
  // during the data phase shows up only on the next read
  function automatic logic [15:0] read_word(input logic [6:0]  addr,
                                            input logic [15:0] ctrl,
                                            input logic [11:0] dir,
                                            input logic [11:0] drv,
                                            input logic [11:0] pin);
    logic [11:0] rb;
    rb = (dir & drv) | (~dir & pin); // RULE1 RULE10
    case (addr)
      `ADDR_PIN_READBACK: read_word = {4'h0, rb}; // RULE2
      `ADDR_CONV_CONTROL: read_word = ctrl;
      default:            read_word = 16'h0000;
    endcase
  endfunction : read_word

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  regbank_pkg::main_state_t st_reg;
  regbank_pkg::main_state_t st_next;

  logic        sclk_rise;
  logic        sclk_fall;
  logic [7:0]  cmd_word;
  logic [15:0] data_word;
  // index of the current frame, captured with the command byte
  logic [6:0]  cmd_addr_q;

  // edges are found on the synchronised serial clock, so each half period
  // must span several system clocks or an edge is lost
  assign sclk_rise = sclk_s & ~st_reg.sclk_q;
  assign sclk_fall = ~sclk_s & st_reg.sclk_q;
  assign cmd_word  = {st_reg.shin[6:0], sdi_s};
  assign data_word = {st_reg.shin[14:0], sdi_s};

  always_comb begin
    st_next            = st_reg;
    st_next.sclk_q     = sclk_s;
    st_next.trig_pulse = 1'b0;
    st_next.load_pulse = 1'b0;
    st_next.dac_update = 4'h0;

    // self-clearing bits are acted on one cycle after they were written
    // the pulse, not the bit, starts the converter; the bit reads one for a cycle
    if (st_reg.ctrl[`CTRL_TRIG_BIT]) begin
      st_next.trig_pulse               = 1'b1; // RULE4
      st_next.ctrl[`CTRL_TRIG_BIT]     = 1'b0; // RULE4
    end

    // pending flags remember which channels have fresh data not yet loaded
    st_next.dac_pending = st_reg.dac_pending;
    if (st_reg.ctrl[`CTRL_LOAD_BIT]) begin
      st_next.load_pulse           = 1'b1;
      st_next.dac_update           = st_reg.dac_pending & dac_sync_i; // RULE5 RULE6
      st_next.dac_pending          = st_reg.dac_pending & ~dac_sync_i; // RULE6
      st_next.ctrl[`CTRL_LOAD_BIT] = 1'b0; // RULE11
    end
    // a data write in the load cycle stays pending for the next load
    st_next.dac_pending = st_next.dac_pending | dac_data_wr_i; // RULE6

    // pins drive only when configured as outputs
    // direction and drive are registered so the pins never glitch from decode
    st_next.pin_oe  = gpio_dir_i; // RULE9
    st_next.pin_drv = gpio_out_i & gpio_dir_i; // RULE9

    // --------------------------------------------------------------
    // serial host port: read flag, 7-bit index, 16 data bits, msb first
    // --------------------------------------------------------------
    // a frame cut by chip select drops its partial bits; nothing is written
    if (csn_s) begin
      st_next.phase   = regbank_pkg::PH_IDLE;
      st_next.bit_cnt = 5'h00;
      st_next.sdo_oe  = 1'b0;
      st_next.sdo     = 1'b0;
    end else begin
      st_next.sdo_oe = 1'b1;
      case (st_reg.phase)
        regbank_pkg::PH_IDLE: begin
          // one idle cycle after select lets the edge detector settle
          st_next.phase   = regbank_pkg::PH_CMD;
          st_next.bit_cnt = 5'h00;
        end
        regbank_pkg::PH_CMD: begin
          if (sclk_rise) begin
            st_next.shin    = data_word;
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == `CMD_LAST) begin
              st_next.rw      = cmd_word[7];
              st_next.shout   = read_word(cmd_word[6:0], st_reg.ctrl, gpio_dir_i,
                                          gpio_out_i, pin_s);
              st_next.shin    = {9'h000, cmd_word[6:0]};
              st_next.bit_cnt = 5'h00;
              st_next.phase   = regbank_pkg::PH_DATA;
            end
          end
        end
        regbank_pkg::PH_DATA: begin
          if (sclk_fall) begin
            st_next.sdo   = st_reg.shout[15];
            st_next.shout = {st_reg.shout[14:0], 1'b0};
          end
          if (sclk_rise) begin
            st_next.shin    = data_word;
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == `DATA_LAST) begin
              // only the control index takes writes; readback and unmapped indices drop them
              if (!st_reg.rw && cmd_addr_q == `ADDR_CONV_CONTROL) begin
                // write wins over the self-clear of the same cycle
                st_next.ctrl = data_word & `CTRL_WMASK; // RULE3 RULE4 RULE5 RULE7
              end
              st_next.bit_cnt = 5'h00;
              st_next.phase   = regbank_pkg::PH_CMD;
            end
          end
        end
        default: begin
          st_next.phase = regbank_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // the index is held apart from the shift register, which the data bits overwrite
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_addr_q <= 7'h00;
    end else if (st_reg.phase == regbank_pkg::PH_CMD && sclk_rise &&
                 st_reg.bit_cnt == `CMD_LAST && !csn_s) begin
      cmd_addr_q <= cmd_word[6:0];
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg       <= '0;
      st_reg.phase <= regbank_pkg::PH_IDLE;
      st_reg.ctrl  <= `CTRL_RESET; // RULE8 RULE3 RULE7
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign spi_sdo_o      = st_reg.sdo;
  assign spi_sdo_oe_o   = st_reg.sdo_oe;
  assign gpio_pin_o     = st_reg.pin_drv;
  assign gpio_pin_oe_o  = st_reg.pin_oe;
  assign dac_update_o   = st_reg.dac_update;
  assign dac_load_o     = st_reg.load_pulse;
  assign conv_trigger_o = st_reg.trig_pulse;
  assign conv_auto_o    = st_reg.ctrl[`CTRL_AUTO_BIT]; // RULE3
  assign conv_rate_o    = st_reg.ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO]; // RULE7

endmodule : gpio_conv_regbank

`default_nettype wire

// ### bench/regbank_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// port checks
// ------------------------------
module regbank_chk (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        spi_csn_i,
  input wire logic [11:0] gpio_dir_i,
  input wire logic [11:0] gpio_out_i,
  input wire logic [11:0] gpio_pin_o,
  input wire logic [11:0] gpio_pin_oe_o,
  input wire logic [3:0]  dac_sync_i,
  input wire logic [3:0]  dac_update_o,
  input wire logic        dac_load_o,
  input wire logic        conv_trigger_o,
  input wire logic        conv_auto_o,
  input wire logic [1:0]  conv_rate_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  chk_pin_drive: assert property ($past(resetn_i) |->
    {gpio_pin_o, gpio_pin_oe_o} == $past({gpio_out_i & gpio_dir_i, gpio_dir_i})) else $error("pin");
  chk_reset_value: assert property ($rose(resetn_i) |-> conv_auto_o && conv_rate_o == 2'h0)
    else $error("reset");
  chk_trig_single: assert property (conv_trigger_o |=> !conv_trigger_o) else $error("trig");
  chk_load_single: assert property (dac_load_o |=> !dac_load_o) else $error("load");
  chk_update_sync: assert property ((dac_update_o & ~$past(dac_sync_i)) == 4'h0)
    else $error("sync");
  chk_update_in_load: assert property (dac_update_o != 4'h0 |-> dac_load_o) else $error("upd");
  chk_rate_hold: assert property (spi_csn_i [*4] |-> $stable(conv_rate_o)) else $error("rate");
  chk_mode_hold: assert property (spi_csn_i [*4] |-> $stable(conv_auto_o)) else $error("mode");
  chk_idle_quiet: assert property (spi_csn_i [*4] |-> !conv_trigger_o) else $error("idle");
  cover property (conv_trigger_o);
  cover property (dac_load_o && dac_update_o != 4'h0);
  cover property (!conv_auto_o);
endmodule : regbank_chk
bind gpio_conv_regbank regbank_chk chk (.mclk_i, .resetn_i, .spi_csn_i, .gpio_dir_i, .gpio_out_i,
  .gpio_pin_o, .gpio_pin_oe_o, .dac_sync_i, .dac_update_o, .dac_load_o, .conv_trigger_o,
  .conv_auto_o, .conv_rate_o);
`default_nettype wire

// ### bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// serial host
// ------------------------------
module host_model (
  input  wire logic mclk_i,
  input  wire logic sdo_i,
  output var  logic csn_o,
  output var  logic sclk_o,
  output var  logic sdi_o
);
  initial begin
    csn_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // six mclk per half period keeps clear of the synchroniser lag
  task automatic half();
    repeat (6) @(negedge mclk_i);
  endtask : half
  task automatic xfer(input logic rd, input logic [6:0] idx, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [23:0] frame;
    frame = {rd, idx, wd};
    rdat = 16'h0000;
    @(negedge mclk_i);
    csn_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_o = frame[i];
      half();
      sclk_o = 1'b1;
      if (i < 16) rdat = {rdat[14:0], sdo_i};
      half();
      sclk_o = 1'b0;
    end
    csn_o = 1'b1;
    sdi_o = ~sdi_o; // released line shows no stale level
    half();
  endtask : xfer
endmodule : host_model
`default_nettype wire

// ### bench/gpio_conv_regbank_tb_top.sv
`timescale 1ns/1ps
`include "regbank_defs.svh"
`default_nettype none
// ------------------------------
// testbench
// ------------------------------
module gpio_conv_regbank_tb_top;
  logic        mclk, resetn, csn, sclk, sdi, sdo, sdo_oe, load, trig, auto;
  logic [11:0] dir, drv, pin;
  logic [3:0]  sync, dwr, upd, upd_seen;
  logic [1:0]  rate;
  logic [7:0]  trig_cnt = 8'h00;
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  gpio_conv_regbank uut (.mclk_i(mclk), .resetn_i(resetn), .spi_csn_i(csn),
    .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .gpio_dir_i(dir),
    .gpio_out_i(drv), .gpio_pin_i(pin), .gpio_pin_o(), .gpio_pin_oe_o(), .dac_sync_i(sync),
    .dac_data_wr_i(dwr), .dac_update_o(upd), .dac_load_o(load), .conv_trigger_o(trig),
    .conv_auto_o(auto), .conv_rate_o(rate));
  // an undriven data line reads as the inverse of its last level
  host_model host (.mclk_i(mclk), .sdo_i(sdo_oe ? sdo : ~sdo), .csn_o(csn), .sclk_o(sclk),
    .sdi_o(sdi));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic rd_chk(input logic [6:0] idx, input logic [15:0] exp);
    logic [15:0] val;
    host.xfer(1'b1, idx, 16'h0000, val);
    compare(val, exp);
  endtask : rd_chk
  task automatic reg_wr(input logic [6:0] idx, input logic [15:0] val);
    logic [15:0] unused;
    host.xfer(1'b0, idx, val, unused);
  endtask : reg_wr
  // trigger pulse count and the last load pattern; the cycle ceiling cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (trig) trig_cnt <= trig_cnt + 8'h01;
    if (load) upd_seen <= upd;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    resetn = 1'b0;
    dir = 12'hF0F;
    drv = 12'hA5A;
    pin = 12'h3C3;
    sync = 4'h7;
    dwr = 4'h0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    repeat (6) @(negedge mclk);
    compare({15'h0000, auto}, 16'h0001);
    rd_chk(`ADDR_CONV_CONTROL, `CTRL_RESET);
    rd_chk(`ADDR_PIN_READBACK, 16'h0ACA);
    drv = 12'h5A5;
    pin = 12'hC3C;
    reg_wr(`ADDR_PIN_READBACK, 16'hFFFF);
    rd_chk(`ADDR_PIN_READBACK, 16'h0535);
    rd_chk(7'h10, 16'h0000);
    reg_wr(`ADDR_CONV_CONTROL, 16'hFFFF);
    rd_chk(`ADDR_CONV_CONTROL, 16'h2300);
    compare({14'h0000, rate}, 16'h0003);
    compare({8'h00, trig_cnt}, 16'h0001);
    reg_wr(`ADDR_CONV_CONTROL, 16'h0000);
    compare({12'h000, rate, 1'b0, auto}, 16'h0000);
    @(negedge mclk) dwr = 4'hD;
    @(negedge mclk) dwr = 4'h0;
    reg_wr(`ADDR_CONV_CONTROL, 16'h0800);
    compare({12'h000, upd_seen}, 16'h0005);
    rd_chk(`ADDR_CONV_CONTROL, 16'h0000);
    sync = 4'hF;
    reg_wr(`ADDR_CONV_CONTROL, 16'h0800);
    compare({12'h000, upd_seen}, 16'h0008);
    reg_wr(`ADDR_CONV_CONTROL, 16'h0800);
    compare({12'h000, upd_seen}, 16'h0000);
    reg_wr(`ADDR_CONV_CONTROL, 16'h1000);
    compare({8'h00, trig_cnt}, 16'h0002);
    test_done();
  end
endmodule : gpio_conv_regbank_tb_top
`default_nettype wire
